// File: rtl/mixed_signal_device_control.sv
// Device control register upper half, GPI level registers and burst addressing
`timescale 1ns/1ps
`default_nettype none

module mixed_signal_device_control
  import msio_ctrl_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = SOFT_RESET_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    clk_en_i,
  // Register access from the serial interface
  input  wire reg_req_t                req_i,
  output logic                         rvalid_o,
  output logic [15:0]                  rdata_o,
  output logic [6:0]                   access_addr_o,
  // Port configuration and sensed state
  input  wire logic [NUM_PORTS-1:0]    port_is_adc_i,
  input  wire logic [NUM_PORTS-1:0]    port_is_dac_i,
  input  wire logic [NUM_PORTS-1:0]    gpi_level_i,
  input  wire logic signed [11:0]      temp_int_i,
  input  wire logic                    temp_int_valid_i,
  // Controls to the analog core
  output dev_ctrl_t                    ctrl_o,
  output logic                         analog_hiz_o,
  output logic                         device_reset_o,
  output logic                         power_on_start_o
);

  // Elaboration checks
  if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_chk
    $error("RESET_CYCLES must be 1 to 255");
  end

  // Smallest configured port above cur; bit 5 flags a hit
  function automatic logic [5:0] next_port(input logic [NUM_PORTS-1:0] mask,
                                           input logic [4:0] cur);
    logic [5:0] res;
    res = 6'h00;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (mask[i] && 5'(i) > cur) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  // Address following prev in a window when contextual stepping applies
  function automatic logic [6:0] ctx_step(input logic [6:0] prev,
                                          input logic [6:0] base,
                                          input logic [NUM_PORTS-1:0] mask);
    logic [6:0] off;
    logic [5:0] hit;
    off = prev - base;
    hit = next_port(mask, off[4:0]);
    if (prev >= base && off < 7'(NUM_PORTS) && hit[5]) begin
      return base + {2'b00, hit[4:0]};
    end
    return prev + 7'h01;
  endfunction

  // State
  dev_ctrl_t  ctrl_q;          // Upper control fields
  logic       rst_busy_q;      // Internal reset in progress
  logic [7:0] rst_cnt_q;       // Cycles left in the internal reset
  logic [6:0] addr_q;          // Address of the last access word
  logic       rvalid_q;        // Read answer strobe
  logic [15:0] rdata_q;        // Read answer data
  logic       hiz_q;           // Analog ports released
  logic       pon_q;           // Power-on sequence start pulse

  // Decoded controls
  logic [6:0] cur_addr;        // Address of the present word
  logic       ctrl_wr;         // Write to device control
  logic       soft_rst_req;    // Software asked for a reset
  logic       thermal_trip;    // Internal sensor above limit
  logic       lp_exit;         // Low power bit cleared by host
  logic [15:0] ctrl_rd;        // Device control readback

  // Burst address: explicit on the first word, stepped afterwards
  always_comb begin
    if (req_i.first) begin
      cur_addr = req_i.addr;
    end else if (!ctrl_q.burst_address_mode) begin
      cur_addr = addr_q + 7'h01;
    end else if (req_i.write) begin
      cur_addr = ctx_step(addr_q, ADDR_DAC_BASE, port_is_dac_i);
    end else begin
      // DAC data reads fall through to a plain increment here
      cur_addr = ctx_step(addr_q, ADDR_ADC_BASE, port_is_adc_i);
    end
  end

  // Event decode; control writes are refused while a reset runs
  always_comb begin
    ctrl_wr      = req_i.valid && req_i.write && cur_addr == ADDR_DEV_CTRL && !rst_busy_q;
    soft_rst_req = ctrl_wr && req_i.wdata[BIT_SOFT_RESET];
    thermal_trip = ctrl_q.thermal_shutdown_enable && ctrl_q.temp_monitor_select[0]
                   && temp_int_valid_i && temp_int_i > TEMP_SHUTDOWN_CODE;
    lp_exit      = ctrl_wr && !req_i.wdata[BIT_SOFT_RESET] && ctrl_q.low_power_enable
                   && !req_i.wdata[BIT_LOW_POWER];
    // Busy flag on top, fields at 14:6, unimplemented low bits read zero
    ctrl_rd      = {rst_busy_q, ctrl_q, 6'h00};
  end

  // Access address tracking for the burst stepping
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      addr_q <= 7'h00;
    end else if (clk_en_i && req_i.valid) begin
      addr_q <= cur_addr;
    end
  end

  // Control fields; any internal reset brings back the defaults
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctrl_q <= DEV_CTRL_DEFAULT;
    end else if (clk_en_i) begin
      if (soft_rst_req || thermal_trip || rst_busy_q) begin
        ctrl_q <= DEV_CTRL_DEFAULT;
      end else if (ctrl_wr) begin
        ctrl_q <= dev_ctrl_t'(req_i.wdata[BIT_BURST_MODE:BIT_DAC_REF]);
      end
    end
  end

  // Internal reset sequencer; bit 15 reads one until it ends
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rst_busy_q <= 1'b0;
      rst_cnt_q  <= 8'h00;
    end else if (clk_en_i) begin
      if (soft_rst_req || thermal_trip) begin
        rst_busy_q <= 1'b1;
        rst_cnt_q  <= 8'(RESET_CYCLES - 1);
      end else if (rst_busy_q) begin
        if (rst_cnt_q == 8'h00) begin
          rst_busy_q <= 1'b0;
        end else begin
          rst_cnt_q <= rst_cnt_q - 8'h01;
        end
      end
    end
  end

  // Power-on sequence start after an internal reset or low power exit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pon_q <= 1'b0;
    end else if (clk_en_i) begin
      pon_q <= lp_exit || (rst_busy_q && rst_cnt_q == 8'h00);
    end
  end

  // Analog ports float in low power and during any reset
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hiz_q <= 1'b1;
    end else if (clk_en_i) begin
      hiz_q <= soft_rst_req || thermal_trip || (rst_busy_q && rst_cnt_q != 8'h00)
               || (ctrl_wr ? req_i.wdata[BIT_LOW_POWER] : ctrl_q.low_power_enable);
    end
  end

  // Read answers, one cycle after the word; unmapped reads return zero
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 16'h0000;
    end else if (clk_en_i) begin
      rvalid_q <= req_i.valid && !req_i.write;
      if (req_i.valid && !req_i.write) begin
        unique case (cur_addr)
          ADDR_GPI_LOW:  rdata_q <= gpi_level_i[GPI_LOW_BITS-1:0];
          ADDR_GPI_HIGH: rdata_q <= {12'h000, gpi_level_i[NUM_PORTS-1:GPI_LOW_BITS]};
          ADDR_DEV_CTRL: rdata_q <= ctrl_rd;
          default:       rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // Outputs straight from flops
  assign ctrl_o           = ctrl_q;
  assign rvalid_o         = rvalid_q;
  assign rdata_o          = rdata_q;
  assign access_addr_o    = addr_q;
  assign analog_hiz_o     = hiz_q;
  assign device_reset_o   = rst_busy_q;
  assign power_on_start_o = pon_q;

endmodule

`default_nettype wire

// File: common/msio_ctrl_pkg.sv
// Package: register map, field layout and timing of the device control bank
package msio_ctrl_pkg;

  // Register addresses on the serial interface (7-bit register space)
  localparam logic [6:0] ADDR_GPI_LOW  = 7'h0B;
  localparam logic [6:0] ADDR_GPI_HIGH = 7'h0C;
  localparam logic [6:0] ADDR_DEV_CTRL = 7'h10;
  localparam logic [6:0] ADDR_ADC_BASE = 7'h40;  // ADC data of port 0
  localparam logic [6:0] ADDR_DAC_BASE = 7'h60;  // DAC data of port 0

  // Device control field positions
  localparam int unsigned BIT_DAC_REF    = 6;
  localparam int unsigned BIT_THERM_SD   = 7;
  localparam int unsigned BIT_TMON_LO    = 8;
  localparam int unsigned BIT_TMON_HI    = 10;
  localparam int unsigned BIT_CONV_EXT   = 11;
  localparam int unsigned BIT_SERIES_RESISTANCE_CANCEL  = 12;
  localparam int unsigned BIT_LOW_POWER  = 13;
  localparam int unsigned BIT_BURST_MODE = 14;
  localparam int unsigned BIT_SOFT_RESET = 15;

  // Value of the upper control fields after any reset
  localparam logic [15:0] DEV_CTRL_RESET = 16'h0000;

  // Number of ports and split of the GPI levels over two registers
  localparam int unsigned NUM_PORTS     = 20;
  localparam int unsigned GPI_LOW_BITS  = 16;
  localparam int unsigned GPI_HIGH_BITS = 4;

  // Thermal shutdown limit, temperature code in 1/8 degree steps
  localparam int unsigned TEMP_SHUTDOWN_DEGC = 145;
  localparam int unsigned TEMP_LSB_PER_DEGC  = 8;
  localparam logic signed [11:0] TEMP_SHUTDOWN_CODE =
    12'(TEMP_SHUTDOWN_DEGC * TEMP_LSB_PER_DEGC);

  // Length of an internal reset, in clock cycles
  localparam int unsigned SOFT_RESET_CYCLES = 4;

  // One register access word from the serial interface
  typedef struct packed {
    logic        valid;  // one-cycle strobe per data word
    logic        write;  // 1 write, 0 read
    logic        first;  // first word of a burst, addr is valid
    logic [6:0]  addr;   // start address, used when first is set
    logic [15:0] wdata;  // write data
  } reg_req_t;

  // Upper control fields as seen by the analog core
  typedef struct packed {
    logic       burst_address_mode;
    logic       low_power_enable;
    logic       series_resistance_cancel;
    logic       temp_conversion_extend;
    logic [2:0] temp_monitor_select;
    logic       thermal_shutdown_enable;
    logic       dac_ref_select;
  } dev_ctrl_t;

  localparam dev_ctrl_t DEV_CTRL_DEFAULT =
    dev_ctrl_t'(DEV_CTRL_RESET[BIT_BURST_MODE:BIT_DAC_REF]);

endpackage

// File: tb/msio_ctrl_monitor.sv
// Port timing checker of the device control bank
`timescale 1ns/1ps
`default_nettype none
module msio_ctrl_monitor
  import msio_ctrl_pkg::*;
#(parameter int unsigned RESET_CYCLES = SOFT_RESET_CYCLES) (
  // Design ports, watched only
  input wire logic mclk_i, rst_b_i, clk_en_i, rvalid_o, temp_int_valid_i,
  input wire logic analog_hiz_o, device_reset_o, power_on_start_o,
  input wire reg_req_t req_i,
  input wire dev_ctrl_t ctrl_o,
  input wire logic [15:0] rdata_o,
  input wire logic [6:0] access_addr_o,
  input wire logic [NUM_PORTS-1:0] port_is_adc_i, port_is_dac_i, gpi_level_i,
  input wire logic signed [11:0] temp_int_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic rd, cw;      // Taken read, accepted control write
  logic [7:0] hi_q;  // Edges seen in internal reset
  assign rd = clk_en_i && req_i.valid && !req_i.write;
  assign cw = clk_en_i && req_i.valid && req_i.write && req_i.first
              && req_i.addr == ADDR_DEV_CTRL && !device_reset_o;
  // Restarts whenever internal reset is low
  always_ff @(posedge mclk_i)
    if (!rst_b_i || !device_reset_o) hi_q <= 8'h00;
    else if (clk_en_i) hi_q <= hi_q + 8'h01;
  sequence s_srst; cw && req_i.wdata[15]; endsequence
  sequence s_quiet; device_reset_o && analog_hiz_o && ctrl_o == DEV_CTRL_DEFAULT; endsequence
  property p_lo; rd && req_i.first && req_i.addr == ADDR_GPI_LOW |=>
    rvalid_o && rdata_o == $past(gpi_level_i[15:0]); endproperty
  property p_hi; rd && req_i.first && req_i.addr == ADDR_GPI_HIGH |=>
    rdata_o == {12'h000, $past(gpi_level_i[19:16])}; endproperty
  property p_fld; cw && !req_i.wdata[15] |=> ctrl_o == $past(req_i.wdata[14:6]); endproperty
  property p_srst; s_srst |=> s_quiet; endproperty
  property p_len; $fell(device_reset_o) |-> power_on_start_o && hi_q == RESET_CYCLES;
  endproperty
  property p_lpx; cw && !req_i.wdata[13] && !req_i.wdata[15] && ctrl_o.low_power_enable
    |=> power_on_start_o; endproperty
  property p_th; clk_en_i && ctrl_o.thermal_shutdown_enable && ctrl_o.temp_monitor_select[0]
    && temp_int_valid_i && temp_int_i > TEMP_SHUTDOWN_CODE |=> device_reset_o; endproperty
  property p_inc; clk_en_i && req_i.valid && !req_i.first && (!ctrl_o.burst_address_mode
    || !req_i.write && access_addr_o[6:5] == 2'b11)
    |=> access_addr_o == $past(access_addr_o) + 7'h01; endproperty
  a_lo: assert property (p_lo) else $error("gpi low");
  a_hi: assert property (p_hi) else $error("gpi high");
  a_fld: assert property (p_fld) else $error("fields");
  a_srst: assert property (p_srst) else $error("soft reset");
  a_len: assert property (p_len) else $error("reset length");
  a_lpx: assert property (p_lpx) else $error("low power exit");
  a_th: assert property (p_th) else $error("thermal");
  a_inc: assert property (p_inc) else $error("step");
endmodule
bind mixed_signal_device_control msio_ctrl_monitor
  #(.RESET_CYCLES(RESET_CYCLES)) i_mon (.*);
`default_nettype wire

// File: tb/host_model.sv
// Serial host model issuing register words
`timescale 1ns/1ps
`default_nettype none
module host_model
  import msio_ctrl_pkg::*;
(
  // Clock and request word
  input  wire logic   mclk_i,
  output var reg_req_t req_o
);
  initial req_o = '0;
  // One word per call; idle shows inverted fields so nothing stale looks valid
  task automatic xfer(input logic w, f, input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk_i) req_o <= '{1'b1, w, f, a, d};
    @(posedge mclk_i) req_o <= '{1'b0, ~w, ~f, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench of the device control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import msio_ctrl_pkg::*;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, rvalid_o, device_reset_o, hiz, pos;
  logic en = 1'b1;                         // Clock enable to the design
  logic [15:0] rdata_o;
  logic [6:0] aa;                          // Address of last word
  logic [19:0] adc = '0, dac = '0, gpi = '0; // Port setup and levels
  logic signed [11:0] temp = '0;
  reg_req_t req;
  dev_ctrl_t ctrl;
  int n_mismatch = 0, samples_checked = 0;
  always #20 mclk_i = ~mclk_i;
  host_model i_host (.mclk_i, .req_o(req));
  // Internal reset set to 4 edges, the same as SOFT_RESET_CYCLES in the package
  mixed_signal_device_control #(.RESET_CYCLES(4)) i_dut (.mclk_i, .rst_b_i,
    .clk_en_i(en), .req_i(req), .rvalid_o, .rdata_o, .access_addr_o(aa),
    .port_is_adc_i(adc), .port_is_dac_i(dac), .gpi_level_i(gpi), .temp_int_i(temp),
    .temp_int_valid_i(1'b1), .ctrl_o(ctrl), .analog_hiz_o(hiz), .device_reset_o,
    .power_on_start_o(pos));
  task automatic chk(string s, logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report;
    $display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [6:0] a, logic [15:0] d);
    i_host.xfer(1'b1, 1'b1, a, d);
  endtask
  // Answer is looked at just after the taking edge
  task automatic rd(logic [6:0] a, logic [15:0] e);
    i_host.xfer(1'b0, 1'b1, a, 16'h0000);
    #1 chk("rvalid", 16'h0001, 16'(rvalid_o));
    chk("rdata", e, rdata_o);
  endtask
  task automatic step(logic w, logic [6:0] e);
    i_host.xfer(w, 1'b0, 7'h00, 16'h0000);
    #1 chk("addr", 16'(e), 16'(aa));
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_rst(logic v);
    int i;
    #1;
    for (i = 0; i < 20 && device_reset_o !== v; i++) #40;
    chk("reset", 16'(v), 16'(device_reset_o));
    if (i == 20) final_report();
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(ADDR_DEV_CTRL, 16'h0000);
    @(posedge mclk_i) gpi <= 20'hA5C3E;
    wr(ADDR_GPI_LOW, 16'hFFFF);
    rd(ADDR_GPI_LOW, 16'h5C3E);
    rd(ADDR_GPI_HIGH, 16'h000A);
    $display("gpi done");
    for (int b = 6; b < 15; b++) begin
      wr(ADDR_DEV_CTRL, 16'h0001 << b);
      if (b == 14) #1 chk("pos", 16'h0001, 16'(pos));
      rd(ADDR_DEV_CTRL, 16'h0001 << b);
      chk("hiz", 16'(b == 13), 16'(hiz));
    end
    $display("fields done");
    @(posedge mclk_i) adc <= 20'h00088;
    dac <= 20'h00020;
    rd(7'h43, 16'h0000);
    step(1'b0, 7'h47);
    rd(7'h60, 16'h0000);
    step(1'b0, 7'h61);
    wr(7'h60, 16'h0123);
    step(1'b1, 7'h65);
    wr(ADDR_DEV_CTRL, 16'h0000);
    rd(7'h43, 16'h0000);
    step(1'b0, 7'h44);
    $display("burst done");
    wr(ADDR_DEV_CTRL, 16'h0180);
    @(posedge mclk_i) temp <= 12'h488;
    repeat (3) @(posedge mclk_i);
    #1 chk("hold", 16'(device_reset_o), 16'h0000);
    @(posedge mclk_i) temp <= 12'h489;
    wait_rst(1'b1);
    wait_rst(1'b0);
    rd(ADDR_DEV_CTRL, 16'h0000);
    $display("thermal done");
    wr(ADDR_DEV_CTRL, 16'h8040);
    rd(ADDR_DEV_CTRL, 16'h8000);
    wait_rst(1'b0);
    rd(ADDR_DEV_CTRL, 16'h0000);
    $display("soft reset done");
    // A word offered while the enable is low must be lost
    @(posedge mclk_i) en <= 1'b0;
    wr(ADDR_DEV_CTRL, 16'h0040);
    en <= 1'b1;
    rd(ADDR_DEV_CTRL, 16'h0000);
    $display("enable done");
    final_report();
  end
endmodule
`default_nettype wire
